// *** ppfs_top.sv ***
// pin function select registers for ports k, l, m and the serial-channel port
`timescale 1ns/10ps
module ppfs_top
  import ppfs_pkg::*;
(
  // clock and power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial unit control bits
  input wire logic transmit_enable_bit,
  input wire logic rx_enable_bit,
  // serial unit data and port data bits for the split pins
  input wire logic [2:0] serial_txd_i,
  input wire logic [2:0] serial_port_gpio_i,
  input wire logic [2:0] sc_rx_pad_i,
  output logic [2:0] serial_rxd_o,
  output logic [2:0] serial_port_gpio_in_o,
  // split pin pad controls
  output logic [2:0] sc_tx_pad_o,
  output logic [2:0] sc_tx_oe_n_o,
  output logic [2:0] sc_rx_serial_o,
  output logic [2:0] sc_rx_pull_o,
  // port k pads
  output logic [7:0] k_periph_o,
  output logic [7:0] k_oe_n_o,
  output logic [7:0] k_pull_o,
  // port l pads
  output logic [7:0] l_periph_o,
  output logic [7:0] l_oe_n_o,
  output logic [7:0] l_pull_o,
  // port m pads
  output logic [7:0] m_periph_o,
  output logic [7:0] m_oe_n_o,
  output logic [7:0] m_pull_o,
  // serial port plain pads, bits 0, 2 and 4 unused: periph and pull held low, oe_n held high
  output logic [7:0] sc_periph_o,
  output logic [7:0] sc_oe_n_o,
  output logic [7:0] sc_pull_o
);

  // ==========================================================================
  // bus front end
  ppfs_state_t state_ff;
  ppfs_state_t nxt_state;
  logic [ADDR_W-1:0] addr_ff;
  logic write_ff;
  logic hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic hresp_ff;
  logic [15:0] k_ff;
  logic [15:0] l_ff;
  logic [15:0] m_ff;
  logic [15:0] sc_ff;

  wire accept = hsel && (htrans == HTRANS_NONSEQ) && hready && (state_ff == ST_IDLE);
  wire wr_en = (state_ff == ST_DATA) && write_ff;
  wire rd_en = (state_ff == ST_DATA) && !write_ff;
  wire k_we = wr_en && (addr_ff == OFS_K);
  wire l_we = wr_en && (addr_ff == OFS_L);
  wire m_we = wr_en && (addr_ff == OFS_M);
  wire sc_we = wr_en && (addr_ff == OFS_SC);
  wire sc_active = !transmit_enable_bit && !rx_enable_bit;

  // the write lands at the end of the first data cycle, so decode from nxt_ values
  wire [15:0] nxt_k = k_we ? hwdata[15:0] : k_ff;
  wire [15:0] nxt_l = l_we ? (hwdata[15:0] & L_WR_MASK) : l_ff;
  wire [15:0] nxt_m = m_we ? hwdata[15:0] : m_ff;
  wire [15:0] nxt_sc = sc_we ? hwdata[15:0] : sc_ff;

  wire [31:0] stat_word = {29'h0000000, sc_active, rx_enable_bit, transmit_enable_bit};
  wire [31:0] rd_word = (addr_ff == OFS_K) ? {16'h0000, k_ff} :
                        (addr_ff == OFS_L) ? {16'h0000, l_ff} :
                        (addr_ff == OFS_M) ? {16'h0000, m_ff} :
                        (addr_ff == OFS_SC) ? {16'h0000, sc_ff} :
                        (addr_ff == OFS_STAT) ? stat_word : 32'h00000000;
  wire [31:0] nxt_hrdata = rd_en ? rd_word : hrdata_ff;
  wire nxt_hreadyout = (state_ff == ST_DATA) || !accept;

  always_comb begin
    case (state_ff)
      ST_IDLE: nxt_state = accept ? ST_DATA : ST_IDLE;
      ST_DATA: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // one wait state on every transfer lets hrdata come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      addr_ff <= 8'h00;
      write_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h00000000;
      hresp_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= accept ? haddr[ADDR_W-1:0] : addr_ff;
      write_ff <= accept ? hwrite : write_ff;
      hreadyout_ff <= nxt_hreadyout;
      hrdata_ff <= nxt_hrdata;
      hresp_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // function registers
  // hresetn is the power-on reset; no other reset, standby or sleep reaches here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k_ff <= K_RESET;
      l_ff <= L_RESET;
      m_ff <= M_RESET;
      sc_ff <= SC_RESET;
    end else begin
      k_ff <= nxt_k;
      l_ff <= nxt_l;
      m_ff <= nxt_m;
      sc_ff <= nxt_sc;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ==========================================================================
  // per-pin decode of the plain pins
  logic [7:0] k_per;
  logic [7:0] k_drv;
  logic [7:0] k_pul;
  logic [7:0] l_per;
  logic [7:0] l_drv;
  logic [7:0] l_pul;
  logic [7:0] m_per;
  logic [7:0] m_drv;
  logic [7:0] m_pul;
  logic [7:0] sc_per;
  logic [7:0] sc_drv;
  logic [7:0] sc_pul;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      wire [1:0] sc_field = sc_active ? nxt_sc[2*gi+1:2*gi] : MODE_PERIPH;
      ppfs_field_decode #(.OUT_OK(K_OUT_MASK[gi]), .NO_PULL(1'b0)) u_k (
        .mode(nxt_k[2*gi+1:2*gi]),
        .periph(k_per[gi]),
        .drive(k_drv[gi]),
        .pull(k_pul[gi])
      );
      ppfs_field_decode #(.OUT_OK(L_OUT_MASK[gi]), .NO_PULL(1'b1)) u_l (
        .mode(nxt_l[2*gi+1:2*gi]),
        .periph(l_per[gi]),
        .drive(l_drv[gi]),
        .pull(l_pul[gi])
      );
      ppfs_field_decode #(.OUT_OK(M_OUT_MASK[gi]), .NO_PULL(1'b0)) u_m (
        .mode(nxt_m[2*gi+1:2*gi]),
        .periph(m_per[gi]),
        .drive(m_drv[gi]),
        .pull(m_pul[gi])
      );
      ppfs_field_decode #(.OUT_OK(SC_OUT_MASK[gi]), .NO_PULL(1'b0)) u_sc (
        .mode(sc_field),
        .periph(sc_per[gi]),
        .drive(sc_drv[gi]),
        .pull(sc_pul[gi])
      );
    end
  endgenerate

  // outputs follow the register in the same edge that stores the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k_periph_o <= 8'h00;
      k_oe_n_o <= 8'hFF;
      k_pull_o <= 8'h00;
      l_periph_o <= 8'h00;
      l_oe_n_o <= 8'hFF;
      l_pull_o <= 8'h00;
      m_periph_o <= 8'h00;
      m_oe_n_o <= 8'hFF;
      m_pull_o <= 8'h00;
      sc_periph_o <= 8'h00;
      sc_oe_n_o <= 8'hFF;
      sc_pull_o <= 8'h00;
    end else begin
      k_periph_o <= k_per;
      k_oe_n_o <= ~k_drv;
      k_pull_o <= k_pul;
      l_periph_o <= l_per;
      l_oe_n_o <= ~l_drv;
      l_pull_o <= l_pul;
      m_periph_o <= m_per;
      m_oe_n_o <= ~m_drv;
      m_pull_o <= m_pul;
      sc_periph_o <= sc_per & ~SC_SPLIT_MASK;
      sc_oe_n_o <= ~sc_drv | SC_SPLIT_MASK;
      sc_pull_o <= sc_pul & ~SC_SPLIT_MASK;
    end
  end

  // ==========================================================================
  // split transmit and receive pins, channel c uses the field of pin 2c
  logic [2:0] nxt_tx_pad;
  logic [2:0] nxt_tx_oe_n;
  logic [2:0] nxt_rx_serial;
  logic [2:0] nxt_rx_pull;
  logic [2:0] nxt_gpio_in;
  logic [2:0] nxt_rxd;

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_chan
      wire [1:0] md = nxt_sc[4*gc+1:4*gc];
      wire gpio_out_sel = sc_active && (md == MODE_OUT);
      wire rx_gpio = sc_active && md[1];
      // one data bit, two pins: output mode never opens the receive pin
      assign nxt_tx_pad[gc] = transmit_enable_bit ? serial_txd_i[gc] : serial_port_gpio_i[gc];
      assign nxt_tx_oe_n[gc] = !(transmit_enable_bit || gpio_out_sel);
      assign nxt_rx_serial[gc] = !rx_gpio;
      assign nxt_rx_pull[gc] = rx_gpio && !md[0];
      assign nxt_gpio_in[gc] = rx_gpio ? sc_rx_pad_i[gc] : 1'b0;
      // idle-high line to the serial unit while the pin belongs to the port
      assign nxt_rxd[gc] = rx_gpio ? 1'b1 : sc_rx_pad_i[gc];
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc_tx_pad_o <= 3'h7;
      sc_tx_oe_n_o <= 3'h7;
      sc_rx_serial_o <= 3'h7;
      sc_rx_pull_o <= 3'h0;
      serial_port_gpio_in_o <= 3'h0;
      serial_rxd_o <= 3'h7;
    end else begin
      sc_tx_pad_o <= nxt_tx_pad;
      sc_tx_oe_n_o <= nxt_tx_oe_n;
      sc_rx_serial_o <= nxt_rx_serial;
      sc_rx_pull_o <= nxt_rx_pull;
      serial_port_gpio_in_o <= nxt_gpio_in;
      serial_rxd_o <= nxt_rxd;
    end
  end

  // ==========================================================================
  // checks
  logic seen_wr_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_wr_ff <= 1'b0;
    end else begin
      seen_wr_ff <= seen_wr_ff || wr_en;
    end
  end

  sequence s_addr_phase;
    hsel && (htrans == HTRANS_NONSEQ) && hready && hreadyout;
  endsequence

  sequence s_write_k;
    s_addr_phase ##0 hwrite && (haddr[ADDR_W-1:0] == OFS_K);
  endsequence

  sequence s_wait_then_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  a_untouched_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !seen_wr_ff |-> (k_ff == K_RESET) && (l_ff == L_RESET) && (m_ff == M_RESET) && (sc_ff == SC_RESET))
    else $error("register left its power-on value without a write");

  a_write_k_lands: assert property (@(posedge hclk) disable iff (!hresetn)
    s_write_k |-> ##2 (k_ff == $past(hwdata[15:0], 1)))
    else $error("port k write not stored");

  a_one_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
    s_addr_phase |=> s_wait_then_ready)
    else $error("transfer did not take exactly one wait state");

  a_l_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (l_ff[3:0] == 4'h0) && !l_oe_n_o[0] == 1'b0)
    else $error("port l reserved bits not zero");

  a_k_decode_pin3: assert property (@(posedge hclk) disable iff (!hresetn)
    seen_wr_ff |-> (k_oe_n_o[3] == (k_ff[7:6] != MODE_OUT)) && (k_pull_o[3] == (k_ff[7:6] == MODE_IN_PU)))
    else $error("port k pin 3 decode wrong");

  a_m_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    ($past(m_ff[3:2]) == MODE_OUT) && $past(!m_we) |-> m_oe_n_o[1] && !m_pull_o[1] && !m_periph_o[1])
    else $error("port m reserved code drives or pulls");

  a_tx_override: assert property (@(posedge hclk) disable iff (!hresetn)
    transmit_enable_bit |=> (sc_tx_oe_n_o == 3'h0) && (sc_tx_pad_o == $past(serial_txd_i)))
    else $error("transmit enable did not take the transmit pins");

  a_rx_override: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_enable_bit |=> (sc_rx_serial_o == 3'h7) && (sc_rx_pull_o == 3'h0))
    else $error("receive enable did not take the receive pins");

  a_sc_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    (transmit_enable_bit || rx_enable_bit) |=> sc_periph_o[7] && sc_periph_o[6] && (sc_oe_n_o == 8'hFF))
    else $error("serial port settings applied while serial unit enabled");

  a_pin4_input: assert property (@(posedge hclk) disable iff (!hresetn)
    sc_active && !sc_we && (sc_ff[9:8] == MODE_IN_PU) |=> sc_rx_pull_o[2] && sc_tx_oe_n_o[2] && !sc_rx_serial_o[2])
    else $error("pin 4 pull-up input mode wrong");

  a_pin4_output: assert property (@(posedge hclk) disable iff (!hresetn)
    sc_active && !sc_we && (sc_ff[9:8] == MODE_OUT) |=> !sc_tx_oe_n_o[2] && sc_rx_serial_o[2])
    else $error("pin 4 general output mode wrong");

endmodule : ppfs_top

// *** ppfs_pkg.sv ***
// shared constants and types for the port pin function select block
package ppfs_pkg;

  // ==========================================================================
  // register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_K = 8'h00;
  localparam logic [7:0] OFS_L = 8'h04;
  localparam logic [7:0] OFS_M = 8'h08;
  localparam logic [7:0] OFS_SC = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // ==========================================================================
  // reset values and masks
  localparam logic [15:0] K_RESET = 16'h0000;
  localparam logic [15:0] L_RESET = 16'h0000;
  localparam logic [15:0] M_RESET = 16'hAAAA;
  localparam logic [15:0] SC_RESET = 16'h8008;
  localparam logic [15:0] L_WR_MASK = 16'hFFF0;

  // ==========================================================================
  // per-pin capabilities, one bit per pin
  localparam logic [7:0] K_OUT_MASK = 8'hFF;
  localparam logic [7:0] L_OUT_MASK = 8'h00;
  localparam logic [7:0] M_OUT_MASK = 8'h00;
  localparam logic [7:0] SC_OUT_MASK = 8'h6A;
  localparam logic [7:0] SC_SPLIT_MASK = 8'h15;

  // ==========================================================================
  // status register fields
  localparam int unsigned STAT_TE_BIT = 0;
  localparam int unsigned STAT_RE_BIT = 1;
  localparam int unsigned STAT_ACT_BIT = 2;

  // ==========================================================================
  // bus and modes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {
    MODE_PERIPH = 2'b00,
    MODE_OUT = 2'b01,
    MODE_IN_PU = 2'b10,
    MODE_IN = 2'b11
  } ppfs_mode_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DATA = 1'b1
  } ppfs_state_t;

endpackage : ppfs_pkg

// *** ppfs_field_decode.sv ***
// decoder of one two-bit pin mode field into pad controls
`timescale 1ns/10ps
module ppfs_field_decode
  import ppfs_pkg::*;
#(
  parameter bit OUT_OK = 1'b1,
  parameter bit NO_PULL = 1'b0
) (
  // mode field
  input wire logic [1:0] mode,
  // pad controls
  output logic periph,
  output logic drive,
  output logic pull
);

  // ==========================================================================
  // decode; reserved codes give a floating input, the safest pad state
  assign periph = (mode == MODE_PERIPH);
  assign drive = OUT_OK && (mode == MODE_OUT);
  assign pull = !NO_PULL && (mode == MODE_IN_PU);

endmodule : ppfs_field_decode

// *** ppfs_pad_model.sv ***
// pad-side model of the receive pins of the three split serial channels
`timescale 1ns/10ps
module ppfs_pad_model (
  // clock
  input wire logic hclk,
  // far-side drive and pad pull-up
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  input wire logic [2:0] pull,
  // pad levels
  output logic [2:0] pad
);
  // ==========================================================================
  // floating pad
  // an undriven pad without pull-up toggles, so a stale level never passes for data
  logic flip_ff = 1'b0;
  always @(posedge hclk) flip_ff <= ~flip_ff;
  assign pad = (ext_en & ext_val) | (~ext_en & pull) | (~ext_en & ~pull & {3{flip_ff}});
endmodule : ppfs_pad_model

// *** ppfs_tb_top.sv ***
// self-checking bench of the port pin function select block
`timescale 1ns/10ps
module ppfs_tb_top;
  import ppfs_pkg::*;
  // ==========================================================================
  // signals
  logic hclk = 1'b0, hresetn, hsel, hwrite, hready, hreadyout, hresp, te, re;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, txd, gpio, rxpad, rxd, gpin, txpad, txoen, rxser, rxpull, ext_en, ext_val;
  logic [7:0] kp, ko, kl, lp, lo, ll, mp, mo, ml, sp, so, sl;
  int num_errors = 0;
  int checks_done = 0;
  always #20 hclk = ~hclk;
  assign hready = hreadyout;
  ppfs_top ppfs_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .transmit_enable_bit(te), .rx_enable_bit(re),
    .serial_txd_i(txd), .serial_port_gpio_i(gpio), .sc_rx_pad_i(rxpad), .serial_rxd_o(rxd),
    .serial_port_gpio_in_o(gpin), .sc_tx_pad_o(txpad), .sc_tx_oe_n_o(txoen), .sc_rx_serial_o(rxser),
    .sc_rx_pull_o(rxpull), .k_periph_o(kp), .k_oe_n_o(ko), .k_pull_o(kl), .l_periph_o(lp),
    .l_oe_n_o(lo), .l_pull_o(ll), .m_periph_o(mp), .m_oe_n_o(mo), .m_pull_o(ml),
    .sc_periph_o(sp), .sc_oe_n_o(so), .sc_pull_o(sl));
  ppfs_pad_model ppfs_pad_model_i (.hclk(hclk), .ext_en(ext_en), .ext_val(ext_val), .pull(rxpull),
    .pad(rxpad));
  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // waits for hready sampled high at a rising edge; ready is read at the negedge before it
  task automatic wait_rdy(output logic [31:0] rd);
    int n;
    logic ok;
    n = 0;
    do begin
      @(negedge hclk);
      ok = (hreadyout === 1'b1);
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (!ok && n < 20);
    if (!ok) begin
      num_errors++;
      complete_run();
    end
  endtask : wait_rdy
  task automatic xfer(input logic [7:0] ofs, input logic wr, input logic [15:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy(rd);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0000, wd};
    wait_rdy(rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer
  task automatic wr(input logic [7:0] ofs, input logic [15:0] wd);
    logic [31:0] d;
    xfer(ofs, 1'b1, wd, d);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] d;
    xfer(ofs, 1'b0, 16'h0000, d);
    chk(name, exp, d);
  endtask : rd_chk
  // ==========================================================================
  // scenarios
  task automatic test_reset_values();
    rd_chk("k reg", OFS_K, 32'h0000);
    rd_chk("l reg", OFS_L, 32'h0000);
    rd_chk("m reg", OFS_M, 32'hAAAA);
    rd_chk("sc reg", OFS_SC, 32'h8008);
    @(negedge hclk);
    chk("k periph", 32'hFF, kp);
    chk("m pull", 32'hFF, ml);
    chk("sc pull", 32'h82, sl);
    @(posedge hclk);
    $display("test reset values done");
  endtask : test_reset_values
  // every port k code on pins 0 to 3 and again on 4 to 7
  task automatic test_port_k();
    wr(OFS_K, 16'hE4E4);
    @(negedge hclk);
    chk("k periph", 32'h11, kp);
    chk("k oe_n", 32'hDD, ko);
    chk("k pull", 32'h44, kl);
    @(posedge hclk);
    rd_chk("k reg", OFS_K, 32'hE4E4);
    $display("test port k done");
  endtask : test_port_k
  // analogue outputs and top pins are unused here, so port l may leave its reset value
  task automatic test_port_l();
    wr(OFS_L, 16'hFFFF);
    rd_chk("l reg", OFS_L, 32'hFFF0);
    wr(OFS_L, 16'hE4EF);
    rd_chk("l reg", OFS_L, 32'hE4E0);
    @(negedge hclk);
    chk("l periph", 32'h10, {24'h0, lp & 8'hFC});
    chk("l oe_n", 32'hFC, {24'h0, lo & 8'hFC});
    chk("l pull", 32'h00, ll);
    @(posedge hclk);
    $display("test port l done");
  endtask : test_port_l
  task automatic test_port_m();
    wr(OFS_M, 16'hE4E4);
    @(negedge hclk);
    chk("m periph", 32'h11, mp);
    chk("m oe_n", 32'hFF, mo);
    chk("m pull", 32'h44, ml);
    @(posedge hclk);
    $display("test port m done");
  endtask : test_port_m
  // pins 7..0 fields 11 01 10 01 00 10 01 11 with the serial unit off
  task automatic test_sc_ports();
    ext_en <= 3'b001;
    ext_val <= 3'b000;
    gpio <= 3'b100;
    wr(OFS_SC, 16'hD927);
    @(negedge hclk);
    chk("sc periph", 32'h08, sp);
    chk("sc oe_n", 32'hBD, so);
    chk("sc pull", 32'h20, sl);
    chk("tx oe_n", 32'h3, txoen);
    chk("tx pad", 32'h4, {29'h0, txpad & 3'b100});
    chk("rx serial", 32'h4, rxser);
    chk("rx pull", 32'h2, rxpull);
    chk("gpio in", 32'h2, gpin);
    chk("serial rxd", 32'h3, {29'h0, rxd & 3'b011});
    @(posedge hclk);
    ext_val <= 3'b001;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("gpio in", 32'h3, gpin);
    @(posedge hclk);
    $display("test serial port done");
  endtask : test_sc_ports
  task automatic test_serial_override();
    txd <= 3'b101;
    te <= 1'b1;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("tx oe_n", 32'h0, txoen);
    chk("tx pad", 32'h5, txpad);
    @(posedge hclk);
    re <= 1'b1;
    ext_en <= 3'b111;
    ext_val <= 3'b011;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("rx serial", 32'h7, rxser);
    chk("serial rxd", 32'h3, rxd);
    chk("sc periph", 32'hEA, sp);
    chk("sc pull", 32'h00, sl);
    @(posedge hclk);
    rd_chk("status", OFS_STAT, 32'h3);
    te <= 1'b0;
    re <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("tx oe_n", 32'h3, txoen);
    @(posedge hclk);
    rd_chk("status", OFS_STAT, 32'h4);
    // pin 4 field 10 with the serial unit off: pull-up input, transmit pin floats
    wr(OFS_SC, 16'h8208);
    @(negedge hclk);
    chk("rx pull", 32'h4, rxpull);
    chk("rx serial", 32'h3, rxser);
    chk("tx oe_n", 32'h7, txoen);
    @(posedge hclk);
    $display("test serial override done");
  endtask : test_serial_override
  task automatic test_unmapped();
    wr(8'h14, 16'hFFFF);
    rd_chk("unmapped", 8'h14, 32'h0);
    wr(OFS_STAT, 16'hFFFF);
    rd_chk("k reg", OFS_K, 32'hE4E4);
    $display("test unmapped done");
  endtask : test_unmapped
  // a second power-on reset in mid-run restores every register
  task automatic test_reinit();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset_values();
    $display("test reinit done");
  endtask : test_reinit
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    te = 1'b0;
    re = 1'b0;
    txd = 3'b000;
    gpio = 3'b000;
    ext_en = 3'b000;
    ext_val = 3'b000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset_values();
    test_port_k();
    test_port_l();
    test_port_m();
    test_sc_ports();
    test_serial_override();
    test_unmapped();
    test_reinit();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    complete_run();
  end
endmodule : ppfs_tb_top
